/* common/drive_stats_pkg.sv */
// constants and carrier types for the drive statistics and fault log block
package drive_stats_pkg;

	// ----------------------------------------------------------------
	// register map, byte addresses on the 32-bit wishbone slave
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W           = 8;
	localparam logic [7:0]  OFS_POWERED      = 8'h00;
	localparam logic [7:0]  OFS_ENABLED      = 8'h04;
	localparam logic [7:0]  OFS_ENERGY       = 8'h08;
	localparam logic [7:0]  OFS_FAN          = 8'h0C;
	localparam logic [7:0]  OFS_CLEAR_SELECT = 8'h10;
	localparam logic [7:0]  OFS_OVERLOAD     = 8'h14;
	localparam logic [7:0]  OFS_ENC_SPEED    = 8'h18;
	localparam logic [7:0]  OFS_ENC_COUNT    = 8'h1C;
	localparam logic [7:0]  OFS_AO_A_FUNC    = 8'h20;
	localparam logic [7:0]  OFS_AO_B_FUNC    = 8'h24;
	localparam logic [7:0]  OFS_ALARM        = 8'h28;
	localparam logic [7:0]  OFS_FAULT        = 8'h2C;
	localparam logic [7:0]  OFS_HIST_BASE    = 8'h40;
	localparam logic [7:0]  HIST_STRIDE      = 8'h08;
	localparam int unsigned HIST_DEPTH       = 10;

	// ----------------------------------------------------------------
	// values with a meaning
	// ----------------------------------------------------------------
	localparam logic [7:0]  CLR_FAN          = 8'h02;
	localparam logic [7:0]  CLR_ENABLED      = 8'h03;
	localparam logic [7:0]  CLR_ENERGY       = 8'h04;
	localparam logic [7:0]  AO_SEL_ENCODER   = 8'h31;
	localparam logic [6:0]  OVERLOAD_TRIP    = 7'h64;
	localparam logic [9:0]  CODE_OVERLOAD    = 10'h048;
	localparam logic [15:0] ENC_COUNT_MAX    = 16'h9C40;
	localparam logic [31:0] RESET_WORD       = 32'h00000000;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam longint unsigned CLK_HZ        = 25_000_000;
	localparam longint unsigned HOUR_SECONDS  = 3600;
	localparam longint unsigned FILTER_MS     = 500;
	localparam longint unsigned HOUR_CYC_DEF  = CLK_HZ * HOUR_SECONDS;
	localparam longint unsigned TENTH_CYC_DEF = HOUR_CYC_DEF / 10;
	localparam longint unsigned FILTER_CYC_DEF = CLK_HZ * FILTER_MS / 1000;
	localparam int unsigned     TICK_W        = 40;
	localparam int unsigned     FILTER_SHIFT  = 4;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0] day;
		logic [3:0] month;
		logic [6:0] year;
		logic [4:0] hour;
		logic [5:0] minute;
	} stamp_type;

	typedef struct packed {
		logic [15:0] powered;
		logic [15:0] enabled;
		logic [15:0] energy;
		logic [15:0] fan;
	} counters_type;

	typedef enum logic [2:0] {
		NV_IDLE = 3'b001,
		NV_SAVE = 3'b010,
		NV_HOLD = 3'b100
	} nv_state_type;

endpackage : drive_stats_pkg

/* design/drive_stats.sv */
// operating statistics and fault log of a motor drive, wishbone slave
//
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
module drive_stats
	import drive_stats_pkg::*;
#(
	parameter logic [TICK_W-1:0] HOUR_CYCLES   = TICK_W'(HOUR_CYC_DEF),
	parameter logic [TICK_W-1:0] TENTH_CYCLES  = TICK_W'(TENTH_CYC_DEF),
	parameter logic [TICK_W-1:0] FILTER_CYCLES = TICK_W'(FILTER_CYC_DEF)
) (
	input  wire logic                clk_i,           // system clock
	input  wire logic                rst_i,           // sync reset, high
	input  wire logic [ADDR_W-1:0]   adr_i,           // wishbone address
	input  wire logic [31:0]         dat_i,           // wishbone write data
	output logic      [31:0]         dat_o,           // wishbone read data
	input  wire logic                we_i,            // wishbone write
	input  wire logic [3:0]          sel_i,           // wishbone lanes
	input  wire logic                cyc_i,           // wishbone cycle
	input  wire logic                stb_i,           // wishbone strobe
	output logic                     ack_o,           // wishbone ack
	input  wire logic                drive_enabled_i, // inverter enabled
	input  wire logic                fan_running_i,   // heatsink fan on
	input  wire logic                kwh_pulse_i,     // one per kWh
	input  wire logic                undervoltage_i,  // DC-link low
	input  wire logic                nv_load_i,       // restore strobe
	input  wire counters_type        nv_load_data_i,  // restored values
	output logic                     nv_save_o,       // save strobe
	output counters_type             nv_save_data_o,  // values to save
	input  wire logic [6:0]          overload_raw_i,  // overload percent
	output logic                     motor_overload_fault_o, // latched
	input  wire logic                enc_step_i,      // one per pulse
	input  wire logic                enc_cw_i,        // 1 = clockwise
	input  wire logic [15:0]         enc_rpm_raw_i,   // unfiltered rpm
	input  wire logic [15:0]         ao_a_source_i,   // normal a value
	input  wire logic [15:0]         ao_b_source_i,   // normal b value
	output logic      [15:0]         ao_a_value_o,    // analog out a
	output logic      [15:0]         ao_b_value_o,    // analog out b
	input  wire logic [9:0]          alarm_code_i,    // present alarm
	input  wire logic                fault_event_i,   // new fault strobe
	input  wire logic [9:0]          fault_code_i,    // its code
	input  wire logic                fault_reset_i,   // fault cleared
	input  wire stamp_type           stamp_now_i      // calendar time
);
	import drive_stats_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] zext16(input logic [15:0] v);
		zext16 = {16'h0000, v};
	endfunction : zext16

	function automatic logic [15:0] ao_route(input logic [7:0] func,
			input logic [15:0] normal, input logic [15:0] count);
		ao_route = (func == AO_SEL_ENCODER) ? count : normal;
	endfunction : ao_route

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	logic        ack_reg;
	logic        ack_next;
	logic [31:0] rdat_reg;
	logic [31:0] rdat_next;
	logic [7:0]  clr_sel_reg;
	logic [7:0]  clr_sel_next;
	logic [7:0]  ao_a_func_reg;
	logic [7:0]  ao_a_func_next;
	logic [7:0]  ao_b_func_reg;
	logic [7:0]  ao_b_func_next;
	logic        take;
	logic        wr_lane0;
	logic        clr_fan;
	logic        clr_enabled;
	logic        clr_energy;
	logic [31:0] rd_mux;
	logic [7:0]  hist_off;
	logic [3:0]  hist_idx;

	logic [15:0] powered;
	logic [15:0] enabled;
	logic [15:0] energy;
	logic [15:0] fan;
	logic [6:0]  ovl_reg;
	logic        ovl_fault_reg;
	logic [15:0] enc_count_reg;
	logic [15:0] speed_out;
	logic [9:0]  alarm_reg;
	logic [9:0]  fault_reg;
	logic [9:0]  hist_code_reg [HIST_DEPTH];
	stamp_type   hist_stamp_reg [HIST_DEPTH];

	assign take = cyc_i & stb_i & ~ack_reg;
	assign wr_lane0 = take & we_i & sel_i[0];
	// clear acts once, on the write itself, not while the value stands
	assign clr_fan = wr_lane0 && adr_i == OFS_CLEAR_SELECT
		&& dat_i[7:0] == CLR_FAN;
	assign clr_enabled = wr_lane0 && adr_i == OFS_CLEAR_SELECT
		&& dat_i[7:0] == CLR_ENABLED;
	assign clr_energy = wr_lane0 && adr_i == OFS_CLEAR_SELECT
		&& dat_i[7:0] == CLR_ENERGY;
	assign hist_off = adr_i - OFS_HIST_BASE;
	assign hist_idx = hist_off[6:3];

	always_comb begin
		rd_mux = RESET_WORD;
		case (adr_i)
			OFS_POWERED:      rd_mux = zext16(powered);
			OFS_ENABLED:      rd_mux = zext16(enabled);
			OFS_ENERGY:       rd_mux = zext16(energy);
			OFS_FAN:          rd_mux = zext16(fan);
			OFS_CLEAR_SELECT: rd_mux = {24'h000000, clr_sel_reg};
			OFS_OVERLOAD:     rd_mux = {23'h000000, ovl_fault_reg,
				1'b0, ovl_reg};
			OFS_ENC_SPEED:    rd_mux = zext16(speed_out);
			OFS_ENC_COUNT:    rd_mux = zext16(enc_count_reg);
			OFS_AO_A_FUNC:    rd_mux = {24'h000000, ao_a_func_reg};
			OFS_AO_B_FUNC:    rd_mux = {24'h000000, ao_b_func_reg};
			OFS_ALARM:        rd_mux = {22'h000000, alarm_reg};
			OFS_FAULT:        rd_mux = {22'h000000, fault_reg};
			default: begin
				// history: code word then stamp word per entry
				// offset bit 7 set would alias onto the first entries
				if (adr_i >= OFS_HIST_BASE && !hist_off[7]
						&& {4'h0, hist_idx} < 8'(HIST_DEPTH)) begin
					if (hist_off[2]) begin
						rd_mux = {5'h00, hist_stamp_reg[hist_idx]};
					end else begin
						rd_mux = {22'h000000, hist_code_reg[hist_idx]};
					end
				end
			end
		endcase
	end

	always_comb begin
		ack_next = take;
		rdat_next = rdat_reg;
		clr_sel_next = clr_sel_reg;
		ao_a_func_next = ao_a_func_reg;
		ao_b_func_next = ao_b_func_reg;
		if (take && !we_i) begin
			rdat_next = rd_mux;
		end
		// only the three settings are writable; the rest is read only
		if (wr_lane0) begin
			case (adr_i)
				OFS_CLEAR_SELECT: clr_sel_next = dat_i[7:0];
				OFS_AO_A_FUNC:    ao_a_func_next = dat_i[7:0];
				OFS_AO_B_FUNC:    ao_b_func_next = dat_i[7:0];
				default:          clr_sel_next = clr_sel_reg;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= RESET_WORD;
			clr_sel_reg <= 8'h00;
			ao_a_func_reg <= 8'h00;
			ao_b_func_reg <= 8'h00;
		end else begin
			ack_reg <= ack_next;
			rdat_reg <= rdat_next;
			clr_sel_reg <= clr_sel_next;
			ao_a_func_reg <= ao_a_func_next;
			ao_b_func_reg <= ao_b_func_next;
		end
	end

	assign ack_o = ack_reg;
	assign dat_o = rdat_reg;

	// ----------------------------------------------------------------
	// usage and energy counters
	// ----------------------------------------------------------------
	usage_counter #(.WIDTH(16), .TICK_W(TICK_W)) u_powered (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.ticks_i      (HOUR_CYCLES),
		.advance_i    (1'b1),
		.clear_i      (1'b0),
		.load_i       (nv_load_i),
		.load_value_i (nv_load_data_i.powered),
		.count_o      (powered)
	);

	usage_counter #(.WIDTH(16), .TICK_W(TICK_W)) u_enabled (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.ticks_i      (TENTH_CYCLES),
		.advance_i    (drive_enabled_i),
		.clear_i      (clr_enabled),
		.load_i       (nv_load_i),
		.load_value_i (nv_load_data_i.enabled),
		.count_o      (enabled)
	);

	// energy estimate from an upstream power integrator, not a meter
	usage_counter #(.WIDTH(16), .TICK_W(TICK_W)) u_energy (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.ticks_i      (TICK_W'(1)),
		.advance_i    (kwh_pulse_i),
		.clear_i      (clr_energy),
		.load_i       (nv_load_i),
		.load_value_i (nv_load_data_i.energy),
		.count_o      (energy)
	);

	usage_counter #(.WIDTH(16), .TICK_W(TICK_W)) u_fan (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.ticks_i      (HOUR_CYCLES),
		.advance_i    (fan_running_i),
		.clear_i      (clr_fan),
		.load_i       (nv_load_i),
		.load_value_i (nv_load_data_i.fan),
		.count_o      (fan)
	);

	// ----------------------------------------------------------------
	// save on undervoltage, once per low-voltage episode
	// ----------------------------------------------------------------
	nv_state_type nv_state_reg;
	nv_state_type nv_state_next;
	counters_type nv_data_reg;
	counters_type nv_data_next;

	always_comb begin
		nv_state_next = nv_state_reg;
		nv_data_next = nv_data_reg;
		case (nv_state_reg)
			NV_IDLE: begin
				if (undervoltage_i) begin
					nv_state_next = NV_SAVE;
					nv_data_next = '{powered, enabled, energy, fan};
				end
			end
			NV_SAVE: nv_state_next = NV_HOLD;
			NV_HOLD: begin
				if (!undervoltage_i) begin
					nv_state_next = NV_IDLE;
				end
			end
			default: nv_state_next = NV_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nv_state_reg <= NV_IDLE;
			nv_data_reg <= '0;
		end else begin
			nv_state_reg <= nv_state_next;
			nv_data_reg <= nv_data_next;
		end
	end

	assign nv_save_o = nv_state_reg == NV_SAVE;
	assign nv_save_data_o = nv_data_reg;

	// ----------------------------------------------------------------
	// encoder count and speed filter
	// ----------------------------------------------------------------
	logic [15:0]       enc_count_next;
	logic [TICK_W-1:0] flt_step_reg;
	logic [TICK_W-1:0] flt_step_next;
	logic [19:0]       flt_acc_reg;
	logic [19:0]       flt_acc_next;

	always_comb begin
		enc_count_next = enc_count_reg;
		if (enc_step_i) begin
			if (enc_cw_i) begin
				enc_count_next = (enc_count_reg >= ENC_COUNT_MAX) ? 16'h0000
					: enc_count_reg + 16'h0001;
			end else begin
				enc_count_next = (enc_count_reg == 16'h0000) ? ENC_COUNT_MAX
					: enc_count_reg - 16'h0001;
			end
		end
		// first-order filter, 16 steps across the half-second window
		flt_step_next = flt_step_reg + 1'b1;
		flt_acc_next = flt_acc_reg;
		if (flt_step_reg >= (FILTER_CYCLES >> FILTER_SHIFT) - 1'b1) begin
			flt_step_next = '0;
			flt_acc_next = flt_acc_reg - (flt_acc_reg >> FILTER_SHIFT)
				+ {4'h0, enc_rpm_raw_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enc_count_reg <= 16'h0000;
			flt_step_reg <= '0;
			flt_acc_reg <= 20'h00000;
		end else begin
			enc_count_reg <= enc_count_next;
			flt_step_reg <= flt_step_next;
			flt_acc_reg <= flt_acc_next;
		end
	end

	assign speed_out = flt_acc_reg[19:4];
	assign ao_a_value_o = ao_route(ao_a_func_reg, ao_a_source_i,
		enc_count_reg);
	assign ao_b_value_o = ao_route(ao_b_func_reg, ao_b_source_i,
		enc_count_reg);

	// ----------------------------------------------------------------
	// overload, active codes and fault history
	// ----------------------------------------------------------------
	logic [6:0]  ovl_next;
	logic        ovl_fault_next;
	logic        ovl_pend_reg;
	logic        ovl_pend_next;
	logic [9:0]  alarm_next;
	logic [9:0]  fault_next;
	logic        new_fault;
	logic [9:0]  new_code;
	logic        ovl_trip;
	logic [9:0]  hist_code_next [HIST_DEPTH];
	stamp_type   hist_stamp_next [HIST_DEPTH];

	// external fault wins a tie; the overload entry waits until fault_event_i drops
	assign new_fault = fault_event_i | ovl_pend_reg;
	assign new_code = fault_event_i ? fault_code_i : CODE_OVERLOAD;

	always_comb begin
		ovl_next = (overload_raw_i > OVERLOAD_TRIP) ? OVERLOAD_TRIP
			: overload_raw_i;
		ovl_trip = ovl_next >= OVERLOAD_TRIP && ovl_reg < OVERLOAD_TRIP;
		ovl_fault_next = ovl_fault_reg;
		if (fault_reset_i) begin
			ovl_fault_next = 1'b0;
		end
		if (ovl_trip) begin
			ovl_fault_next = 1'b1;
		end
		ovl_pend_next = ovl_pend_reg;
		if (ovl_pend_reg && !fault_event_i) begin
			ovl_pend_next = 1'b0;
		end
		if (ovl_trip) begin
			ovl_pend_next = 1'b1;
		end
		alarm_next = alarm_code_i;
		fault_next = fault_reg;
		if (fault_reset_i) begin
			fault_next = 10'h000;
		end
		if (new_fault) begin
			fault_next = new_code;
		end
		for (int i = 0; i < HIST_DEPTH; i++) begin
			hist_code_next[i] = hist_code_reg[i];
			hist_stamp_next[i] = hist_stamp_reg[i];
		end
		if (new_fault) begin
			for (int i = HIST_DEPTH - 1; i > 0; i--) begin
				hist_code_next[i] = hist_code_reg[i-1];
				hist_stamp_next[i] = hist_stamp_reg[i-1];
			end
			hist_code_next[0] = new_code;
			// stamp taken as is; unset calendar at power-up gives junk
			hist_stamp_next[0] = stamp_now_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovl_reg <= 7'h00;
			ovl_fault_reg <= 1'b0;
			ovl_pend_reg <= 1'b0;
			alarm_reg <= 10'h000;
			fault_reg <= 10'h000;
			for (int i = 0; i < HIST_DEPTH; i++) begin
				hist_code_reg[i] <= 10'h000;
				hist_stamp_reg[i] <= '0;
			end
		end else begin
			ovl_reg <= ovl_next;
			ovl_fault_reg <= ovl_fault_next;
			ovl_pend_reg <= ovl_pend_next;
			alarm_reg <= alarm_next;
			fault_reg <= fault_next;
			for (int i = 0; i < HIST_DEPTH; i++) begin
				hist_code_reg[i] <= hist_code_next[i];
				hist_stamp_reg[i] <= hist_stamp_next[i];
			end
		end
	end

	assign motor_overload_fault_o = ovl_fault_reg;

endmodule : drive_stats

/* design/usage_counter.sv */
// wrapping usage counter with its own prescaler, clear and restore
`timescale 1ns/1ns
module usage_counter #(
	parameter int unsigned WIDTH  = 16,
	parameter int unsigned TICK_W = 40
) (
	input  wire logic              clk_i,        // system clock
	input  wire logic              rst_i,        // sync reset, high
	input  wire logic [TICK_W-1:0] ticks_i,      // clocks per count unit
	input  wire logic              advance_i,    // qualifying condition
	input  wire logic              clear_i,      // zero count, one cycle
	input  wire logic              load_i,       // restore, one cycle
	input  wire logic [WIDTH-1:0]  load_value_i, // restored value
	output logic      [WIDTH-1:0]  count_o       // present count
);
	logic [TICK_W-1:0] pre_reg;
	logic [TICK_W-1:0] pre_next;
	logic [WIDTH-1:0]  count_reg;
	logic [WIDTH-1:0]  count_next;

	always_comb begin
		pre_next = pre_reg;
		count_next = count_reg;
		if (advance_i) begin
			// full-width counter wraps to zero by itself
			if (pre_reg >= ticks_i - 1'b1) begin
				pre_next = '0;
				count_next = count_reg + 1'b1;
			end else begin
				pre_next = pre_reg + 1'b1;
			end
		end
		if (load_i) begin
			count_next = load_value_i;
		end
		// clear beats restore and advance; partial unit is dropped too
		if (clear_i) begin
			count_next = '0;
			pre_next = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_reg <= '0;
			count_reg <= '0;
		end else begin
			pre_reg <= pre_next;
			count_reg <= count_next;
		end
	end

	assign count_o = count_reg;

endmodule : usage_counter

/* test/drive_stats_properties.sv */
// concurrent checks on the statistics block ports
`timescale 1ns/1ns
module drive_stats_props
	import drive_stats_pkg::*;
(
	input wire logic              clk_i,                  // clock
	input wire logic              rst_i,                  // sync reset
	input wire logic [ADDR_W-1:0] adr_i,                  // address
	input wire logic              we_i,                   // write
	input wire logic              cyc_i,                  // cycle
	input wire logic              stb_i,                  // strobe
	input wire logic              ack_o,                  // ack
	input wire logic [31:0]       dat_o,                  // read data
	input wire logic              undervoltage_i,         // dc-link low
	input wire logic              nv_save_o,              // save strobe
	input wire logic [6:0]        overload_raw_i,         // overload
	input wire logic              fault_reset_i,          // fault clear
	input wire logic              motor_overload_fault_o  // fault flag
);
	import drive_stats_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_answer_a: assert property (cyc_i && stb_i && !ack_o
		|=> ack_o)
		else $error("request not acknowledged next cycle");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without a request");
	read_hold_a: assert property ($changed(dat_o) |-> ack_o)
		else $error("read data changed outside an ack");
	unmapped_zero_a: assert property (ack_o && $past(adr_i) == 8'h30
		&& !$past(we_i) |-> dat_o == 32'h0)
		else $error("unmapped read not zero");
	save_cause_a: assert property (nv_save_o |-> $past(undervoltage_i))
		else $error("save without undervoltage");
	save_start_a: assert property ($rose(undervoltage_i)
		|-> ##[1:2] nv_save_o)
		else $error("undervoltage did not start a save");
	save_pulse_a: assert property (nv_save_o |=> !nv_save_o)
		else $error("save strobe longer than one cycle");
	overload_trip_a: assert property (
		$rose(overload_raw_i >= OVERLOAD_TRIP) && !fault_reset_i
		|-> ##[1:2] motor_overload_fault_o)
		else $error("overload at full level raised no fault");
	overload_hold_a: assert property ($fell(motor_overload_fault_o)
		|-> $past(fault_reset_i))
		else $error("overload fault dropped without a clear");
endmodule : drive_stats_props

bind drive_stats drive_stats_props drive_stats_props_inst (
	.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .we_i(we_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o),
	.undervoltage_i(undervoltage_i), .nv_save_o(nv_save_o),
	.overload_raw_i(overload_raw_i), .fault_reset_i(fault_reset_i),
	.motor_overload_fault_o(motor_overload_fault_o)
);

/* test/nv_store_model.sv */
// nonvolatile storage model that keeps and restores the counters
`timescale 1ns/1ns
module nv_store_model
	import drive_stats_pkg::*;
(
	input  wire logic         clk_i,       // clock
	input  wire logic         save_i,      // save strobe
	input  wire counters_type save_data_i, // values to keep
	output logic              load_o,      // restore strobe
	output counters_type      load_data_o  // restored values
);
	import drive_stats_pkg::*;
	counters_type image = '0;
	initial begin
		load_o = 1'b0;
		load_data_o = '1;
	end
	// keeps the last snapshot across a power loss
	always @(posedge clk_i)
		if (save_i === 1'b1)
			image <= save_data_i;
	task restore(input counters_type v);
		@(posedge clk_i);
		load_o <= 1'b1;
		load_data_o <= v;
		@(posedge clk_i);
		load_o <= 1'b0;
		// released bus shows junk, so a stale value cannot pass
		load_data_o <= ~v;
	endtask : restore
endmodule : nv_store_model

/* test/tb_drive_stats.sv */
// self-checking bench for the drive statistics block
`timescale 1ns/1ns
module tb_drive_stats;
	import drive_stats_pkg::*;
	logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, ack_o;
	logic [7:0]   adr_i = 0;
	logic [31:0]  dat_i = 0, dat_o, q, p0;
	logic en = 0, fan = 0, kwh = 0, uv = 0, ld, sv, ovf, stp = 0, cw = 1;
	logic frst = 0, fev = 0;
	counters_type ld_data, sv_data;
	logic [6:0]   ovl = 0;
	logic [15:0]  rpm = 16'h03E8, sa = 16'h0ABC, sb = 16'h0DEF, ao_a, ao_b;
	logic [9:0]   alarm = 0, fcode = 0;
	stamp_type    stamp = {5'h1F, 4'hC, 7'h63, 5'h17, 6'h3B};
	logic [7:0]   clr_adr [2:4] = '{OFS_FAN, OFS_ENABLED, OFS_ENERGY};
	int fail_count = 0, compares = 0;

	initial forever #20 clk_i = ~clk_i;

	drive_stats #(.HOUR_CYCLES(40'h14), .TENTH_CYCLES(40'h4),
		.FILTER_CYCLES(40'h20)) drive_stats_inst (
		.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
		.dat_o(dat_o), .we_i(we_i), .sel_i(4'hF), .cyc_i(cyc_i),
		.stb_i(stb_i), .ack_o(ack_o), .drive_enabled_i(en),
		.fan_running_i(fan), .kwh_pulse_i(kwh), .undervoltage_i(uv),
		.nv_load_i(ld), .nv_load_data_i(ld_data), .nv_save_o(sv),
		.nv_save_data_o(sv_data), .overload_raw_i(ovl),
		.motor_overload_fault_o(ovf), .enc_step_i(stp), .enc_cw_i(cw),
		.enc_rpm_raw_i(rpm), .ao_a_source_i(sa), .ao_b_source_i(sb),
		.ao_a_value_o(ao_a), .ao_b_value_o(ao_b), .alarm_code_i(alarm),
		.fault_event_i(fev), .fault_code_i(fcode), .fault_reset_i(frst),
		.stamp_now_i(stamp));
	nv_store_model nv_store_model_inst (.clk_i(clk_i), .save_i(sv),
		.save_data_i(sv_data), .load_o(ld), .load_data_o(ld_data));

	// ----------------------------------------
	// bus and check helpers
	// ----------------------------------------
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1;
		stb_i <= 1;
		adr_i <= a;
		we_i <= w;
		dat_i <= d;
		// no local limit: only the watchdog ends a wait for ack
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
	endtask : wb
	task rd(input logic [7:0] a, input logic [31:0] e, input string n);
		wb(a, 0, 0);
		chk(n, e, q);
	endtask : rd
	task wait_cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask : wait_cyc
	task kwh_pulse;
		@(posedge clk_i);
		kwh <= 1;
		@(posedge clk_i);
		kwh <= 0;
	endtask : kwh_pulse
	task enc_step(input logic d);
		@(posedge clk_i);
		cw <= d;
		stp <= 1;
		@(posedge clk_i);
		stp <= 0;
	endtask : enc_step
	task wrap_up;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up

	initial begin
		wait_cyc(20000);
		fail_count++;
		wrap_up;
	end

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		wait_cyc(5);
		rst_i <= 0;
		wb(OFS_ENABLED, 1, 32'h1234);
		rd(OFS_ENABLED, 0, "enabled ro");
		wb(8'h30, 1, 32'h55);
		rd(8'h30, 0, "unmapped");
		$display("test reset done");
		en <= 1;
		fan <= 1;
		kwh_pulse;
		kwh_pulse;
		wait_cyc(98);
		en <= 0;
		fan <= 0;
		uv <= 1;
		wait_cyc(4);
		chk("saved fan", 5, nv_store_model_inst.image.fan);
		chk("saved kwh", 2, nv_store_model_inst.image.energy);
		chk("saved en", 25, nv_store_model_inst.image.enabled);
		uv <= 0;
		wb(OFS_CLEAR_SELECT, 1, 32'h5);
		rd(OFS_CLEAR_SELECT, 5, "clear select");
		rd(OFS_ENERGY, 2, "kwh kept");
		for (int i = 2; i <= 4; i++) begin
			wb(OFS_CLEAR_SELECT, 1, i);
			rd(clr_adr[i], 0, "cleared");
		end
		en <= 1;
		wait_cyc(22);
		en <= 0;
		rd(OFS_ENABLED, 5, "enabled tenths");
		fan <= 1;
		wait_cyc(65);
		fan <= 0;
		rd(OFS_FAN, 3, "fan hours");
		wb(OFS_POWERED, 0, 0);
		p0 = q;
		wait_cyc(200);
		wb(OFS_POWERED, 0, 0);
		chk("powered step", 1, 32'((q - p0) inside {10, 11}));
		nv_store_model_inst.restore({16'h7, 16'h0, 16'hFFFF, 16'h0});
		rd(OFS_ENERGY, 32'hFFFF, "kwh restored");
		kwh_pulse;
		rd(OFS_ENERGY, 0, "kwh wrap");
		$display("test counters done");
		ovl <= OVERLOAD_TRIP;
		wait_cyc(3);
		chk("overload flag", 1, ovf);
		rd(OFS_OVERLOAD, 32'h164, "overload reg");
		rd(OFS_FAULT, CODE_OVERLOAD, "fault code");
		rd(OFS_HIST_BASE, CODE_OVERLOAD, "hist 72");
		frst <= 1;
		ovl <= 7'h32;
		wait_cyc(1);
		frst <= 0;
		wait_cyc(2);
		chk("overload clear", 0, ovf);
		rd(OFS_OVERLOAD, 32'h32, "overload level");
		for (int i = 1; i <= 11; i++) begin
			@(posedge clk_i);
			fcode <= 10'(i);
			fev <= 1;
		end
		@(posedge clk_i);
		fev <= 0;
		rd(OFS_FAULT, 11, "active fault");
		for (int j = 0; j < 10; j++)
			rd(8'(OFS_HIST_BASE + HIST_STRIDE * j), 11 - j, "hist");
		rd(8'(OFS_HIST_BASE + 4), 32'(stamp), "stamp");
		wb(OFS_HIST_BASE, 1, 0);
		rd(OFS_HIST_BASE, 11, "hist ro");
		rd(8'hC0, 0, "hist alias");
		alarm <= 10'h3E7;
		wait_cyc(2);
		rd(OFS_ALARM, 32'h3E7, "alarm");
		$display("test faults done");
		enc_step(0);
		rd(OFS_ENC_COUNT, ENC_COUNT_MAX, "ccw wrap");
		wb(OFS_AO_A_FUNC, 1, AO_SEL_ENCODER);
		chk("ao a enc", ENC_COUNT_MAX, ao_a);
		chk("ao b src", sb, ao_b);
		enc_step(1);
		wb(OFS_AO_B_FUNC, 1, AO_SEL_ENCODER);
		chk("ao a wrap", 0, ao_a);
		chk("ao b enc", 0, ao_b);
		enc_step(1);
		wb(OFS_AO_A_FUNC, 1, 0);
		rd(OFS_ENC_COUNT, 1, "cw count");
		chk("ao a src", sa, ao_a);
		rd(OFS_ENC_SPEED, 32'h3E8, "speed");
		$display("test encoder done");
		wrap_up;
	end
endmodule : tb_drive_stats
